/* File: shared/mss_cfg.svh */
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH

// Counts, limits and reset values.
`define MSS_NSTAGE 15
`define MSS_NONE 4'hF
`define MSS_FREQ_RST 16'h01F4
`define MSS_T1_RST 16'h0032
`define MSS_TIME_MAX 16'h7FFF

// Register byte offsets and block numbers.
`define MSS_OFF_PRESET 12'h000
`define MSS_OFF_ENABLE 12'h040
`define MSS_OFF_MODE 12'h044
`define MSS_OFF_STATUS 12'h048
`define MSS_OFF_ELAPSED 12'h04C
`define MSS_BLK_SETUP 6'h02
`define MSS_BLK_TIME 6'h03

// Mode word digit positions.
`define MSS_MODE_UNIT 3:0
`define MSS_MODE_TEN 7:4
`define MSS_MODE_HUND 11:8
`define MSS_MODE_THOU 15:12

// Stage setting digit positions.
`define MSS_SET_SRC 3:0
`define MSS_SET_DIR 7:4
`define MSS_SET_ACC 11:8

// Bus answers.
`define MSS_RESP_OKAY 2'h0
`define MSS_RESP_SLVERR 2'h2

// Time base: one tenth of a second in ns, clock period in ns.
`define MSS_TENTH_NS 100000000
`define MSS_CLK_NS 4
`define MSS_TENTH_CYC (`MSS_TENTH_NS / `MSS_CLK_NS)
`define MSS_SEC_PER_MIN 60

`endif

/* File: shared/mss_pkg.sv */
package mss_pkg;

   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_RUN,
      SEQ_PAUSED,
      SEQ_HOLD,
      SEQ_DONE
   } mss_seq_t;

   typedef struct packed {
      logic [15:0] freq;
      logic dir;
      logic [1:0] acc_sel;
   } mss_cmd_t;

   typedef struct packed {
      logic [14:0][15:0] preset;
      logic [14:0][11:0] setup;
      logic [14:0][15:0] stime;
      logic enable;
      logic [15:0] mode;
      mss_seq_t seq;
      logic [3:0] stage;
      logic [15:0] elapsed;
      logic [15:0] rec_freq;
      logic use_rec;
      logic run_q;
      mss_cmd_t cmd;
      logic stop_req;
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mss_state_t;

   typedef struct packed {
      logic [31:0] count;
      logic [5:0] sub;
      logic tick;
   } mss_tick_state_t;

endpackage

/* File: core/mss_tick.sv */
`timescale 1ns/100ps
`include "mss_cfg.svh"

module mss_tick
   import mss_pkg::*;
#(
   parameter int unsigned TENTH_CYC = `MSS_TENTH_CYC
)
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_resetn,
   // Control.
   input wire logic i_count,
   input wire logic i_minutes,
   // One pulse per tenth of the selected unit.
   output logic o_tick
);

   mss_tick_state_t s_reg;
   mss_tick_state_t s_next;

   // The prescaler pauses rather than clears, so a resumed stage keeps
   // its partial tenth.
   always_comb
   begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (i_count)
      begin
         if (s_reg.count >= TENTH_CYC - 1)
         begin
            s_next.count = 32'h0000_0000;
            if (!i_minutes || s_reg.sub >= 6'(`MSS_SEC_PER_MIN - 1))
            begin
               s_next.sub = 6'h00;
               s_next.tick = 1'b1;
            end
            else
            begin
               s_next.sub = s_reg.sub + 6'h01;
            end
         end
         else
         begin
            s_next.count = s_reg.count + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign o_tick = s_reg.tick;

   AST_TICK_ONLY_COUNTING: assert property (@(posedge i_clk)
      disable iff (!i_resetn) o_tick |-> $past(i_count))
      else $error("Tick without counting.");

endmodule // mss_tick

/* File: core/mss_top.sv */
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "mss_cfg.svh"

module mss_top
   import mss_pkg::*;
#(
   parameter int unsigned TENTH_CYC = `MSS_TENTH_CYC
)
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_resetn,
   // AXI4-Lite write channels.
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [11:0] i_s_axi_awaddr,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   output logic [1:0] o_s_axi_bresp,
   // AXI4-Lite read channels.
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   input wire logic [11:0] i_s_axi_araddr,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   // Run command logic.
   input wire logic i_run,
   input wire logic i_fault,
   input wire logic i_power_fail,
   input wire logic i_cmd_dir,
   input wire logic i_dir_valid,
   // Frequencies in 0.01 Hz.
   input wire logic [15:0] i_chan_freq,
   input wire logic [15:0] i_out_freq,
   // Drive speed control core.
   output mss_cmd_t o_cmd,
   output logic o_active,
   output logic o_stop_req,
   output logic [3:0] o_stage
);

   mss_state_t s_reg;
   mss_state_t s_next;
   logic tick;

   function automatic logic [3:0] sat_digit(input logic [3:0] d,
                                            input logic [3:0] max);
      sat_digit = (d > max) ? max : d;
   endfunction

   // First stage at or after start with a nonzero time.
   function automatic logic [3:0] find_stage(input logic [3:0] start,
      input logic [14:0][15:0] t);
      logic [3:0] r;
      r = `MSS_NONE;
      for (int i = `MSS_NSTAGE - 1; i >= 0; i--)
      begin
         if (4'(i) >= start && t[i] != 16'h0000)
            r = 4'(i);
      end
      find_stage = r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            r[8*b +: 8] = d[8*b +: 8];
      end
      merge = r;
   endfunction

   mss_tick #(
      .TENTH_CYC(TENTH_CYC)
   ) u_tick (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_count(s_reg.seq == SEQ_RUN),
      .i_minutes(s_reg.mode[`MSS_MODE_THOU] != 4'h0),
      .o_tick(tick)
   );

   logic [3:0] unit_d;
   logic [3:0] ten_d;
   logic keep_on_pf;
   logic run_rise;
   logic [11:0] cur_set;
   logic [3:0] nxt;
   logic [31:0] wv;
   logic [3:0] widx;
   logic [3:0] ridx;
   logic [5:0] rblk;

   always_comb
   begin
      s_next = s_reg;
      unit_d = s_reg.mode[`MSS_MODE_UNIT];
      ten_d = s_reg.mode[`MSS_MODE_TEN];
      keep_on_pf = s_reg.mode[`MSS_MODE_HUND] != 4'h0;
      run_rise = i_run && !s_reg.run_q;
      s_next.run_q = i_run;
      cur_set = s_reg.setup[s_reg.stage];
      nxt = `MSS_NONE;
      wv = 32'h0000_0000;
      widx = 4'h0;
      ridx = 4'h0;
      rblk = 6'h00;

      // Sequencer.
      case (s_reg.seq)
         SEQ_IDLE:
         begin
            s_next.stop_req = 1'b0;
            if (run_rise && !i_fault)
            begin
               nxt = find_stage(4'h0, s_reg.stime);
               s_next.elapsed = 16'h0000;
               s_next.use_rec = 1'b0;
               if (nxt == `MSS_NONE)
               begin
                  s_next.seq = SEQ_DONE;
               end
               else
               begin
                  s_next.seq = SEQ_RUN;
                  s_next.stage = nxt;
               end
            end
         end
         SEQ_RUN:
         begin
            if (i_power_fail && (!keep_on_pf || ten_d == 4'h0))
            begin
               s_next.seq = SEQ_IDLE;
               s_next.stage = 4'h0;
               s_next.elapsed = 16'h0000;
               s_next.use_rec = 1'b0;
            end
            else if (!i_run || i_fault || i_power_fail)
            begin
               if (ten_d == 4'h0)
               begin
                  s_next.seq = SEQ_IDLE;
                  s_next.stage = 4'h0;
                  s_next.elapsed = 16'h0000;
                  s_next.use_rec = 1'b0;
               end
               else
               begin
                  s_next.seq = SEQ_PAUSED;
                  if (ten_d == 4'h2)
                  begin
                     s_next.rec_freq = i_out_freq;
                     s_next.use_rec = 1'b1;
                  end
               end
            end
            else if (s_reg.stime[s_reg.stage] == 16'h0000 ||
                     (tick && s_reg.elapsed + 16'h0001 >=
                      s_reg.stime[s_reg.stage]))
            begin
               s_next.elapsed = 16'h0000;
               s_next.use_rec = 1'b0;
               nxt = find_stage(s_reg.stage + 4'h1, s_reg.stime);
               if (nxt != `MSS_NONE)
                  s_next.stage = nxt;
               else if (unit_d == 4'h0)
                  s_next.seq = SEQ_DONE;
               else if (unit_d == 4'h1)
                  s_next.seq = SEQ_HOLD;
               else
               begin
                  nxt = find_stage(4'h0, s_reg.stime);
                  if (nxt == `MSS_NONE)
                     s_next.seq = SEQ_DONE;
                  else
                     s_next.stage = nxt;
               end
            end
            else if (tick)
            begin
               s_next.elapsed = s_reg.elapsed + 16'h0001;
            end
         end
         SEQ_PAUSED:
         begin
            if (i_power_fail && !keep_on_pf)
            begin
               s_next.seq = SEQ_IDLE;
               s_next.stage = 4'h0;
               s_next.elapsed = 16'h0000;
               s_next.use_rec = 1'b0;
            end
            else if (run_rise && !i_fault)
            begin
               s_next.seq = SEQ_RUN;
            end
         end
         SEQ_HOLD:
         begin
            if (!i_run || i_fault || i_power_fail)
               s_next.seq = SEQ_IDLE;
         end
         SEQ_DONE:
         begin
            s_next.stop_req = 1'b1;
            if (!i_run)
               s_next.seq = SEQ_IDLE;
         end
         default:
            s_next.seq = SEQ_IDLE;
      endcase
      if (!s_reg.enable)
      begin
         s_next.seq = SEQ_IDLE;
         s_next.stop_req = 1'b0;
         s_next.stage = 4'h0;
         s_next.elapsed = 16'h0000;
         s_next.use_rec = 1'b0;
      end

      // Command to the speed core; frozen while holding the last value.
      if (s_reg.seq == SEQ_RUN)
      begin
         if (s_reg.use_rec)
            s_next.cmd.freq = s_reg.rec_freq;
         else if (cur_set[`MSS_SET_SRC] == 4'h0)
            s_next.cmd.freq = s_reg.preset[s_reg.stage];
         else
            s_next.cmd.freq = i_chan_freq;
         case (cur_set[`MSS_SET_DIR])
            4'h0: s_next.cmd.dir = 1'b0;
            4'h1: s_next.cmd.dir = 1'b1;
            default: s_next.cmd.dir = i_dir_valid ? i_cmd_dir : s_reg.cmd.dir;
         endcase
         s_next.cmd.acc_sel = 2'(cur_set[`MSS_SET_ACC]);
      end

      // Register writes.
      if (!s_reg.aw_got && i_s_axi_awvalid && !s_reg.bvalid)
      begin
         s_next.aw_got = 1'b1;
         s_next.awaddr = i_s_axi_awaddr;
      end
      if (!s_reg.w_got && i_s_axi_wvalid && !s_reg.bvalid)
      begin
         s_next.w_got = 1'b1;
         s_next.wdata = i_s_axi_wdata;
         s_next.wstrb = i_s_axi_wstrb;
      end
      if (s_reg.aw_got && s_reg.w_got)
      begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = `MSS_RESP_OKAY;
         widx = s_reg.awaddr[5:2];
         case (s_reg.awaddr[11:6])
            6'h00:
            begin
               if (widx < 4'(`MSS_NSTAGE))
               begin
                  wv = merge({16'h0000, s_reg.preset[widx]}, s_reg.wdata,
                             s_reg.wstrb);
                  s_next.preset[widx] = wv[15:0];
               end
               else
                  s_next.bresp = `MSS_RESP_SLVERR;
            end
            6'h01:
            begin
               if ({s_reg.awaddr[11:2], 2'h0} == `MSS_OFF_ENABLE)
               begin
                  wv = merge({31'h0, s_reg.enable}, s_reg.wdata, s_reg.wstrb);
                  s_next.enable = wv[0];
               end
               else if ({s_reg.awaddr[11:2], 2'h0} == `MSS_OFF_MODE)
               begin
                  wv = merge({16'h0000, s_reg.mode}, s_reg.wdata, s_reg.wstrb);
                  s_next.mode = {sat_digit(wv[15:12], 4'h1),
                                 sat_digit(wv[11:8], 4'h1),
                                 sat_digit(wv[7:4], 4'h2),
                                 sat_digit(wv[3:0], 4'h2)};
               end
               else
                  s_next.bresp = `MSS_RESP_SLVERR;
            end
            `MSS_BLK_SETUP:
            begin
               if (widx < 4'(`MSS_NSTAGE))
               begin
                  wv = merge({20'h00000, s_reg.setup[widx]}, s_reg.wdata,
                             s_reg.wstrb);
                  s_next.setup[widx] = {sat_digit(wv[11:8], 4'h3),
                                        sat_digit(wv[7:4], 4'h2),
                                        sat_digit(wv[3:0], 4'h1)};
               end
               else
                  s_next.bresp = `MSS_RESP_SLVERR;
            end
            `MSS_BLK_TIME:
            begin
               if (widx < 4'(`MSS_NSTAGE))
               begin
                  wv = merge({16'h0000, s_reg.stime[widx]}, s_reg.wdata,
                             s_reg.wstrb);
                  s_next.stime[widx] = (wv[15:0] > `MSS_TIME_MAX) ?
                     `MSS_TIME_MAX : wv[15:0];
               end
               else
                  s_next.bresp = `MSS_RESP_SLVERR;
            end
            default:
               s_next.bresp = `MSS_RESP_SLVERR;
         endcase
      end
      if (s_reg.bvalid && i_s_axi_bready)
         s_next.bvalid = 1'b0;

      // Register reads.
      if (s_reg.rvalid && i_s_axi_rready)
         s_next.rvalid = 1'b0;
      if (!s_reg.rvalid && i_s_axi_arvalid)
      begin
         s_next.rvalid = 1'b1;
         s_next.rresp = `MSS_RESP_OKAY;
         s_next.rdata = 32'h0000_0000;
         ridx = i_s_axi_araddr[5:2];
         rblk = i_s_axi_araddr[11:6];
         if (ridx < 4'(`MSS_NSTAGE) && rblk == 6'h00)
            s_next.rdata = {16'h0000, s_reg.preset[ridx]};
         else if (ridx < 4'(`MSS_NSTAGE) && rblk == `MSS_BLK_SETUP)
            s_next.rdata = {20'h00000, s_reg.setup[ridx]};
         else if (ridx < 4'(`MSS_NSTAGE) && rblk == `MSS_BLK_TIME)
            s_next.rdata = {16'h0000, s_reg.stime[ridx]};
         else if ({i_s_axi_araddr[11:2], 2'h0} == `MSS_OFF_ENABLE)
            s_next.rdata = {31'h0, s_reg.enable};
         else if ({i_s_axi_araddr[11:2], 2'h0} == `MSS_OFF_MODE)
            s_next.rdata = {16'h0000, s_reg.mode};
         else if ({i_s_axi_araddr[11:2], 2'h0} == `MSS_OFF_STATUS)
            s_next.rdata = {22'h0, s_reg.use_rec, s_reg.stop_req, 1'b0,
                            s_reg.seq, s_reg.stage};
         else if ({i_s_axi_araddr[11:2], 2'h0} == `MSS_OFF_ELAPSED)
            s_next.rdata = {16'h0000, s_reg.elapsed};
         else
            s_next.rresp = `MSS_RESP_SLVERR;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s_reg <= '0;
         s_reg.preset <= {`MSS_NSTAGE{`MSS_FREQ_RST}};
         s_reg.stime[0] <= `MSS_T1_RST;
      end
      else
         s_reg <= s_next;
   end

   assign o_s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
   assign o_s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
   assign o_s_axi_bvalid = s_reg.bvalid;
   assign o_s_axi_bresp = s_reg.bresp;
   assign o_s_axi_arready = !s_reg.rvalid;
   assign o_s_axi_rvalid = s_reg.rvalid;
   assign o_s_axi_rdata = s_reg.rdata;
   assign o_s_axi_rresp = s_reg.rresp;
   assign o_cmd = s_reg.cmd;
   assign o_active = (s_reg.seq == SEQ_RUN) || (s_reg.seq == SEQ_HOLD);
   assign o_stop_req = s_reg.stop_req;
   assign o_stage = s_reg.stage;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_stop_in_run;
      s_reg.seq == SEQ_RUN && s_reg.enable && !i_run;
   endsequence

   sequence s_resume;
      s_reg.seq == SEQ_PAUSED && s_reg.enable && run_rise && !i_fault &&
      !i_power_fail;
   endsequence

   AST_DISABLED_IDLE: assert property (!s_reg.enable |=>
      s_reg.seq == SEQ_IDLE && !o_active)
      else $error("Sequencer ran while disabled.");
   AST_MODE_DIGITS: assert property (s_reg.mode[3:0] <= 4'h2 &&
      s_reg.mode[7:4] <= 4'h2 && s_reg.mode[15:8] <= 8'h11 &&
      s_reg.mode[11:8] <= 4'h1)
      else $error("Mode digit out of range.");
   AST_DONE_STOPS: assert property (s_reg.seq == SEQ_DONE && i_run &&
      s_reg.enable |=> o_stop_req && s_reg.seq == SEQ_DONE)
      else $error("Single cycle did not stop.");
   AST_HOLD_FREEZE: assert property (s_reg.seq == SEQ_HOLD &&
      $past(s_reg.seq == SEQ_HOLD) |-> $stable(o_cmd))
      else $error("Held command changed.");
   AST_RESTART_FIRST: assert property (s_stop_in_run ##0
      (s_reg.mode[7:4] == 4'h0) |=> s_reg.seq == SEQ_IDLE &&
      s_reg.elapsed == 16'h0000)
      else $error("Interrupted sequence not reset.");
   AST_RESUME_STAGE: assert property (s_resume |=>
      s_reg.seq == SEQ_RUN && $stable(s_reg.stage) &&
      $stable(s_reg.elapsed))
      else $error("Resume lost stage or time.");
   AST_RECORD_FREQ: assert property (s_stop_in_run ##0
      (s_reg.mode[7:4] == 4'h2) |=> s_reg.use_rec &&
      s_reg.rec_freq == $past(i_out_freq) ##0
      (s_reg.seq == SEQ_PAUSED))
      else $error("Frequency not recorded.");
   AST_PRESET_SOURCE: assert property (s_reg.seq == SEQ_RUN &&
      !s_reg.use_rec && cur_set[3:0] == 4'h0 |=>
      o_cmd.freq == $past(s_reg.preset[s_reg.stage]))
      else $error("Preset frequency not applied.");
   AST_ACC_SELECT: assert property (s_reg.seq == SEQ_RUN |=>
      o_cmd.acc_sel == $past(cur_set[9:8]))
      else $error("Wrong accel set.");
   AST_STAGE_VALID: assert property ($rose(s_reg.seq == SEQ_RUN) |->
      s_reg.stime[s_reg.stage] != 16'h0000)
      else $error("Zero time stage entered.");

endmodule // mss_top

/* File: verif/mss_drive_model.sv */
`timescale 1ns/100ps

module mss_drive_model
   import mss_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_resetn,
   // Command from the sequencer.
   input wire mss_cmd_t i_cmd,
   // Measured output frequency.
   output logic [15:0] o_out_freq
);
   // A fixed slip keeps the measured speed apart from the command.
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_out_freq <= 16'h0000;
      else
         o_out_freq <= i_cmd.freq - 16'h0010;
   end
endmodule // mss_drive_model

/* File: verif/multi_speed_stage_sequencer_tb_top.sv */
`timescale 1ns/100ps

module multi_speed_stage_sequencer_tb_top
   import mss_pkg::*;
;
   logic clk, rstn, awv, wv, bready, arv, rready, run, fault, pfail;
   logic cdir, dvalid, awready, wready, bvalid, arready, rvalid;
   logic active, stopq;
   logic saw1 = 1'b0;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic [15:0] chf, outf;
   logic [3:0] stage;
   mss_cmd_t cmd;
   int error_cnt, num_checks;

   mss_top #(.TENTH_CYC(4)) dut_u (.i_clk(clk), .i_resetn(rstn),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awready),
      .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wready),
      .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
      .i_s_axi_arvalid(arv), .o_s_axi_arready(arready),
      .i_s_axi_araddr(ara), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .i_run(run), .i_fault(fault), .i_power_fail(pfail), .i_cmd_dir(cdir),
      .i_dir_valid(dvalid), .i_chan_freq(chf), .i_out_freq(outf),
      .o_cmd(cmd), .o_active(active), .o_stop_req(stopq), .o_stage(stage));
   mss_drive_model drv_u (.i_clk(clk), .i_resetn(rstn), .i_cmd(cmd),
      .o_out_freq(outf));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Flags any visit to stage 1, whose time is zero.
   always @(negedge clk)
      if (active === 1'b1 && stage === 4'h1)
         saw1 <= 1'b1;

   task automatic finish_test();
      if (error_cnt == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      int n;
      logic ha, hw, hb;
      hb = 1'b0;
      @(posedge clk);
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      awa <= a;
      wd <= d;
      for (n = 0; n < 100 && !hb; n++)
      begin
         @(negedge clk);
         ha = awv & awready;
         hw = wv & wready;
         hb = bvalid;
         rs = bresp;
         @(posedge clk);
         awv <= awv & ~ha;
         wv <= wv & ~hw;
         bready <= ~hb;
      end
      chk("bvalid", 32'h1, hb);
   endtask

   task automatic axr(input logic [11:0] a);
      int n;
      logic ha, hr;
      hr = 1'b0;
      @(posedge clk);
      arv <= 1'b1;
      rready <= 1'b1;
      ara <= a;
      for (n = 0; n < 100 && !hr; n++)
      begin
         @(negedge clk);
         ha = arv & arready;
         hr = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge clk);
         arv <= arv & ~ha;
         rready <= ~hr;
      end
      chk("rvalid", 32'h1, hr);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      axr(a);
      chk($sformatf("reg %h", a), e, rd);
   endtask

   task automatic go();
      @(posedge clk);
      run <= 1'b0;
      @(posedge clk);
      run <= 1'b1;
   endtask

   task automatic halt();
      @(posedge clk);
      run <= 1'b0;
      cyc(3);
   endtask

   task automatic wst(input logic [3:0] s);
      int n;
      for (n = 0; n < 400 && !(active === 1'b1 && stage === s); n++)
         @(negedge clk);
      chk("stage", s, stage);
   endtask

   task automatic t_reset();
      rdc(12'h000, 32'h0000_01F4);
      rdc(12'h038, 32'h0000_01F4);
      rdc(12'h040, 32'h0000_0000);
      rdc(12'h044, 32'h0000_0000);
      rdc(12'h080, 32'h0000_0000);
      rdc(12'h0C0, 32'h0000_0032);
      rdc(12'h0C4, 32'h0000_0000);
      axr(12'h100);
      chk("unmapped rresp", 32'h2, rs);
      go();
      cyc(4);
      chk("active disabled", 32'h0, active);
      halt();
   endtask

   task automatic t_sat();
      axw(12'h044, 32'h0000_9999);
      rdc(12'h044, 32'h0000_1122);
      axw(12'h088, 32'h0000_0999);
      rdc(12'h088, 32'h0000_0321);
      axw(12'h0C4, 32'h0000_FFFF);
      rdc(12'h0C4, 32'h0000_7FFF);
      axw(12'h0C4, 32'h0000_0000);
      axw(12'h100, 32'h0000_0005);
      chk("unmapped bresp", 32'h2, rs);
   endtask

   task automatic t_single();
      int n;
      axw(12'h088, 32'h0000_0310);
      axw(12'h008, 32'h0000_1234);
      axw(12'h0C0, 32'h0000_0002);
      axw(12'h0C8, 32'h0000_0002);
      axw(12'h044, 32'h0000_0000);
      axw(12'h040, 32'h0000_0001);
      go();
      cyc(4);
      chk("freq stage0", 32'h01F4, cmd.freq);
      wst(4'h2);
      cyc(2);
      chk("freq stage2", 32'h1234, cmd.freq);
      chk("dir stage2", 32'h1, cmd.dir);
      chk("acc stage2", 32'h3, cmd.acc_sel);
      for (n = 0; n < 200 && stopq !== 1'b1; n++)
         @(negedge clk);
      chk("stop_req", 32'h1, stopq);
      chk("active done", 32'h0, active);
      halt();
   endtask

   task automatic t_hold();
      axw(12'h044, 32'h0000_0001);
      go();
      cyc(60);
      chk("active hold", 32'h1, active);
      chk("stage hold", 32'h2, stage);
      chk("freq hold", 32'h1234, cmd.freq);
      chk("dir hold", 32'h1, cmd.dir);
      halt();
   endtask

   task automatic t_wrap();
      axw(12'h0C8, 32'h0000_000A);
      axw(12'h088, 32'h0000_0221);
      axw(12'h044, 32'h0000_0002);
      go();
      wst(4'h2);
      cyc(2);
      chk("freq channel", 32'h0777, cmd.freq);
      chk("dir follow", 32'h1, cmd.dir);
      chk("acc set", 32'h2, cmd.acc_sel);
      @(posedge clk);
      cdir <= 1'b0;
      cyc(3);
      chk("dir live", 32'h0, cmd.dir);
      @(posedge clk);
      dvalid <= 1'b0;
      cdir <= 1'b1;
      cyc(2);
      chk("dir kept", 32'h0, cmd.dir);
      @(posedge clk);
      dvalid <= 1'b1;
      wst(4'h0);
      halt();
   endtask

   task automatic t_resume();
      axw(12'h0C0, 32'h0000_0014);
      axw(12'h044, 32'h0000_0020);
      go();
      cyc(16);
      halt();
      axr(12'h048);
      chk("state paused", 32'h2, rd[6:4]);
      go();
      cyc(4);
      chk("freq recorded", 32'h01E4, cmd.freq);
      halt();
      @(posedge clk);
      pfail <= 1'b1;
      @(posedge clk);
      pfail <= 1'b0;
      cyc(2);
      axr(12'h048);
      chk("state discarded", 32'h0, rd[6:4]);
   endtask

   task automatic t_keep();
      logic [15:0] e;
      axw(12'h044, 32'h0000_0110);
      go();
      cyc(16);
      @(posedge clk);
      fault <= 1'b1;
      @(posedge clk);
      fault <= 1'b0;
      cyc(2);
      axr(12'h04C);
      e = rd[15:0];
      go();
      cyc(4);
      chk("freq stage", 32'h01F4, cmd.freq);
      axr(12'h04C);
      chk("elapsed kept", 32'h1, rd[15:0] >= e && e > 16'h0000);
      @(posedge clk);
      pfail <= 1'b1;
      @(posedge clk);
      pfail <= 1'b0;
      cyc(2);
      axr(12'h048);
      chk("state kept", 32'h2, rd[6:4]);
      go();
      cyc(2);
      chk("active on", 32'h1, active);
      axw(12'h040, 32'h0000_0000);
      cyc(1);
      chk("active off", 32'h0, active);
      axw(12'h040, 32'h0000_0001);
      halt();
   endtask

   task automatic t_first();
      axw(12'h044, 32'h0000_0000);
      go();
      wst(4'h2);
      halt();
      go();
      cyc(4);
      chk("restart stage", 32'h0, stage);
      halt();
      axw(12'h044, 32'h0000_1000);
      go();
      cyc(100);
      axr(12'h04C);
      chk("elapsed minutes", 32'h0, rd);
      axr(12'h048);
      chk("state minutes", 32'h1, rd[6:4]);
      halt();
   endtask

   initial
   begin
      #200000;
      error_cnt++;
      finish_test();
   end

   initial
   begin
      {rstn, awv, wv, bready, arv, rready, run, fault, pfail} = '0;
      {awa, ara, wd} = '0;
      chf = 16'h0777;
      cdir = 1'b1;
      dvalid = 1'b1;
      error_cnt = 0;
      num_checks = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      cyc(2);
      t_reset();
      t_sat();
      t_single();
      t_hold();
      t_wrap();
      t_resume();
      t_keep();
      t_first();
      chk("zero time stage", 32'h0, saw1);
      finish_test();
   end
endmodule // multi_speed_stage_sequencer_tb_top
